// ### dv/dfc_decoder_assertions.sv
// checker bound to the decoder ports
// assumes rising-edge clk and rst asynchronous active high
`timescale 1ns/1ns
module dfc_decoder_assertions (
    input logic clk, rst, setup_valid, query_ack, query_stall, prog_cmd, cmd_error,
    input logic check_done, check_blank, prefix_disable_flag,
    input logic [7:0] setup_type, setup_code, status_code,
    input logic [15:0] setup_value, setup_length, cmd_start_block,
    input logic [31:0] query_data, cmd_byte_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // well-formed support query, and one with the right code but a wrong value
    wire logic q_ok = setup_valid && setup_type == 8'ha1 && setup_code == 8'h42
        && setup_value == 16'h0023 && setup_length == 16'h0004;
    wire logic q_bad = setup_valid && setup_type == 8'ha1 && setup_code == 8'h42
        && setup_value != 16'h0023;
    query_ans_a: assert property (q_ok |=> query_ack && query_data[31:16] == 16'h0001)
        else $error("query answer wrong");
    query_stall_a: assert property (q_bad |=> query_stall && !query_ack)
        else $error("bad query not stalled");
    ack_cause_a: assert property (query_ack |-> $past(q_ok))
        else $error("unrequested query answer");
    block_addr_a:
        assert property (prog_cmd |-> cmd_byte_addr == {6'h0, cmd_start_block, 10'h0})
        else $error("block address wrong");
    pulse_one_a: assert property (prog_cmd |=> !prog_cmd [*8])
        else $error("header pulse repeated");
    check_res_a:
        assert property (check_done |=> status_code == ($past(check_blank) ? 8'h00 : 8'h05))
        else $error("blank check status wrong");
    bad_op_a: assert property (cmd_error |-> ##[0:1] status_code == 8'h01)
        else $error("bad opcode status wrong");
    prefix_rst_a: assert property ($fell(rst) |-> !prefix_disable_flag)
        else $error("prefix not on after reset");
    cover property (q_ok);
    cover property (prog_cmd);
    cover property (check_done && !check_blank);
endmodule : dfc_decoder_assertions
bind dfc_decoder dfc_decoder_assertions chk_u (.clk, .rst, .setup_valid, .query_ack,
    .query_stall, .prog_cmd, .cmd_error, .check_done, .check_blank, .prefix_disable_flag,
    .setup_type, .setup_code, .status_code, .setup_value, .setup_length, .cmd_start_block,
    .query_data, .cmd_byte_addr);

// ### dv/dfc_host_model.sv
// host model: download payloads and class setup requests
// assumes the decoder samples on the rising edge; this side moves on the falling edge
`timescale 1ns/1ns
module dfc_host_model (
    input logic clk, dn_ready,
    output logic dn_start, dn_valid, setup_valid,
    output logic [7:0] dn_data, setup_type, setup_code,
    output logic [15:0] dn_length, setup_value, setup_length
);
    // idle host at time zero; only the value field of a query ever varies
    initial begin
        {dn_start, dn_valid, setup_valid, dn_data, dn_length, setup_value} = '0;
        setup_type = 8'ha1;
        setup_code = 8'h42;
        setup_length = 16'h0004;
    end
    // one request; gap idles the bus between bytes to play a slow host
    task automatic send(input logic [7:0] b[$], input int gap);
        @(negedge clk);
        dn_start <= 1'b1;
        dn_length <= 16'(b.size());
        @(negedge clk);
        dn_start <= 1'b0;
        foreach (b[i]) begin
            dn_valid <= 1'b1;
            dn_data <= b[i];
            // ready is settled between edges; the byte goes at the first edge seeing it high
            for (int n = 0; n < 200 && !dn_ready; n++) @(negedge clk);
            @(negedge clk);
            if (gap > 0) begin
                dn_valid <= 1'b0;
                dn_data <= ~b[i];
                repeat (gap) @(negedge clk);
            end
        end
        // request fully taken before the caller may start the next one
        dn_valid <= 1'b0;
        if (gap == 0) dn_data <= ~dn_data;
    endtask : send
    // one-cycle class request strobe
    task automatic query(input logic [15:0] val);
        @(negedge clk);
        setup_valid <= 1'b1;
        setup_value <= val;
        @(negedge clk);
        setup_valid <= 1'b0;
    endtask : query
endmodule : dfc_host_model

// ### dv/dfu_download_command_decoder_tb.sv
// bench for the download command decoder
// assumes the host model drives requests; this bench is flash engine and image sink
`timescale 1ns/1ns
module dfu_download_command_decoder_tb;
    import dfc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, img_ready = 1'b0, check_done = 1'b0, check_blank = 1'b0;
    dfc_dfu_state_e dfu_state = DFC_IDLE;
    logic dn_start, dn_valid, dn_ready, setup_valid, query_ack, query_stall, img_valid;
    logic dn_end, prog_cmd, read_cmd, check_cmd, erase_cmd, info_cmd, reset_cmd, cmd_error;
    logic prefix_disable_flag;
    logic [7:0] dn_data, setup_type, setup_code, img_data, status_code, seen, img_q[$];
    logic [15:0] dn_length, setup_value, setup_length, cmd_start_block;
    logic [31:0] query_data, cmd_length, cmd_byte_addr, upload_total;
    int error_cnt = 0, checks = 0;
    always #25 clk = ~clk;
    // sticky record of one-cycle pulses, and bytes leaving the fifo
    always @(posedge clk) begin
        seen <= seen | {dn_end, cmd_error, reset_cmd, info_cmd, erase_cmd, check_cmd,
            read_cmd, prog_cmd};
        if (img_valid && img_ready) img_q.push_back(img_data);
    end
    dfc_host_model host_u (.clk, .dn_ready, .dn_start, .dn_valid, .setup_valid, .dn_data,
        .setup_type, .setup_code, .dn_length, .setup_value, .setup_length);
    dfc_decoder #(.DATA_W(8), .FIFO_DEPTH(32)) dut_u (.clk, .rst, .dfu_state, .dn_start,
        .dn_length, .dn_data, .dn_valid, .dn_ready, .setup_valid, .setup_type, .setup_code,
        .setup_value, .setup_length, .query_ack, .query_stall, .query_data, .img_data,
        .img_valid, .img_ready, .dn_end, .prog_cmd, .read_cmd, .check_cmd, .erase_cmd,
        .info_cmd, .reset_cmd, .cmd_start_block, .cmd_length, .cmd_byte_addr, .cmd_error,
        .check_done, .check_blank, .status_code, .prefix_disable_flag, .upload_total);
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // one header in idle state; reserved bytes zero
    task automatic cmd(input logic [7:0] op, b1, input logic [15:0] blk,
        input logic [31:0] len, input logic [7:0] exp);
        seen = 8'h00;
        host_u.send('{op, b1, blk[7:0], blk[15:8], len[7:0], len[15:8], len[23:16],
            len[31:24]}, 0);
        repeat (2) @(negedge clk);
        chk("pulse", seen, exp);
    endtask : cmd
    task automatic t_query;
        host_u.query(16'h0023);
        chk("ack", query_ack, 1'b1);
        chk("version", query_data[31:16], 16'h0001);
        chk("signature", query_data[15:0], 16'h5a3c);
        host_u.query(16'h0024);
        chk("stall", query_stall, 1'b1);
        $display("query test done");
    endtask : t_query
    // header plus 40 bytes; sink stalls until the fifo refuses, then drains it
    task automatic t_prog;
        logic [7:0] b[$] = '{8'h01, 8'h00, 8'h02, 8'h01, 8'h10, 8'h20, 8'h30, 8'h40};
        for (int n = 0; n < 40; n++) b.push_back(8'(n + 9));
        seen = 8'h00;
        fork
            host_u.send(b, 0);
            begin
                repeat (70) @(negedge clk);
                chk("ready", dn_ready, 1'b0);
                img_ready <= 1'b1;
            end
        join
        for (int n = 0; n < 300 && img_q.size() < 40; n++) @(negedge clk);
        chk("pulse", seen, 8'h01);
        chk("addr", cmd_byte_addr, 32'h40800);
        chk("len", cmd_length, 32'h40302010);
        chk("count", img_q.size(), 40);
        foreach (img_q[n]) chk("img", img_q[n], 8'(n + 9));
        $display("program test done");
    endtask : t_prog
    task automatic t_ops;
        cmd(8'h02, 8'h00, 16'h0005, 32'h20, 8'h02);
        chk("upload", upload_total, 32'h28);
        cmd(8'h06, 8'h01, 16'h0000, 32'h0, 8'h00);
        chk("binary", prefix_disable_flag, 1'b1);
        cmd(8'h02, 8'h00, 16'h0005, 32'h20, 8'h02);
        chk("upload", upload_total, 32'h20);
        cmd(8'h03, 8'h00, 16'h0004, 32'h100, 8'h04);
        for (int n = 0; n < 2; n++) begin
            @(negedge clk);
            check_done <= 1'b1;
            check_blank <= n[0];
            @(negedge clk);
            check_done <= 1'b0;
            chk("status", status_code, n ? 8'h00 : 8'h05);
        end
        cmd(8'h04, 8'h00, 16'h0003, 32'h5, 8'h08);
        chk("blocks", cmd_length, 32'h5);
        chk("start", cmd_start_block, 16'h0003);
        cmd(8'h05, 8'h00, 16'h0000, 32'h0, 8'h10);
        cmd(8'h07, 8'h00, 16'h0000, 32'h0, 8'h20);
        cmd(8'h09, 8'h00, 16'h0000, 32'h0, 8'h40);
        chk("bad", status_code, 8'h01);
        $display("command test done");
    endtask : t_ops
    // outside idle a header shape is plain data
    task automatic t_idle;
        logic [7:0] none[$];
        dfu_state <= DFC_DN_IDLE;
        seen = 8'h00;
        img_q.delete();
        host_u.send('{8'h01, 8'h00, 8'h02, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00}, 1);
        for (int n = 0; n < 300 && img_q.size() < 8; n++) @(negedge clk);
        chk("pulse", seen, 8'h00);
        chk("count", img_q.size(), 8);
        host_u.send(none, 0);
        repeat (2) @(negedge clk);
        chk("end", seen[7], 1'b1);
        $display("data state test done");
    endtask : t_idle
    initial begin
        repeat (4) @(negedge clk);
        rst <= 1'b0;
        t_query;
        t_prog;
        t_ops;
        t_idle;
        tally_and_finish;
    end
    // run needs well under a thousand cycles; wide margin
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish;
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
endmodule : dfu_download_command_decoder_tb

// ### rtl/dfc_decoder.sv
// download command decoder: header parse, support query answer, upload prefix state
// assumes the usb core delivers download payload as a byte stream with a start strobe,
// and that flash actions are carried out by a downstream engine that reports results
`timescale 1ns/1ns
`include "dfc_defines.svh"
module dfc_decoder #(
    parameter int DATA_W = 8,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire dfc_pkg::dfc_dfu_state_e dfu_state,
    input wire logic dn_start,
    input wire logic [15:0] dn_length,
    input wire logic [DATA_W-1:0] dn_data,
    input wire logic dn_valid,
    output logic dn_ready,
    input wire logic setup_valid,
    input wire logic [7:0] setup_type,
    input wire logic [7:0] setup_code,
    input wire logic [15:0] setup_value,
    input wire logic [15:0] setup_length,
    output logic query_ack,
    output logic query_stall,
    output logic [31:0] query_data,
    output logic [DATA_W-1:0] img_data,
    output logic img_valid,
    input wire logic img_ready,
    output logic dn_end,
    output logic prog_cmd,
    output logic read_cmd,
    output logic check_cmd,
    output logic erase_cmd,
    output logic info_cmd,
    output logic reset_cmd,
    output logic [15:0] cmd_start_block,
    output logic [31:0] cmd_length,
    output logic [31:0] cmd_byte_addr,
    output logic cmd_error,
    input wire logic check_done,
    input wire logic check_blank,
    output logic [7:0] status_code,
    output logic prefix_disable_flag,
    output logic [31:0] upload_total
);
    import dfc_pkg::*;
    // identity signature, value is arbitrary
    parameter logic [15:0] SIGNATURE = 16'h5a3c;
    dfc_seq_e seq_q; // decode sequence
    logic [7:0] command_header_bytes [8]; // header capture
    logic [2:0] idx_q; // header byte index
    logic [15:0] left_q; // payload bytes remaining
    logic hdr_done;
    logic [7:0] op;
    logic [15:0] f_block;
    logic [31:0] f_len;
    logic fifo_in_ready;
    logic fifo_valid;
    logic [DATA_W-1:0] fifo_data;
    logic take;
    logic img_push;
    assign take = dn_valid && dn_ready;
    assign img_push = (seq_q == DFC_S_DATA) && dn_valid;
    // header and skipped bytes are always taken, data waits for fifo room
    assign dn_ready = (seq_q == DFC_S_HDR) || (seq_q == DFC_S_SKIP) ||
        ((seq_q == DFC_S_DATA) && fifo_in_ready);
    assign hdr_done = (seq_q == DFC_S_HDR) && take && (idx_q == `DFC_HDR_LAST);
    // fields assembled little-endian, last byte taken from the bus
    assign op = command_header_bytes[`DFC_B_OP];
    assign f_block = {command_header_bytes[`DFC_B_BLK_HI], command_header_bytes[`DFC_B_BLK_LO]};
    assign f_len = {dn_data[7:0], command_header_bytes[`DFC_B_LEN2],
        command_header_bytes[`DFC_B_LEN1], command_header_bytes[`DFC_B_LEN0]};

    // image byte fifo; its back-pressure stalls the download stream
    dfc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_data(dn_data),
        .in_valid(img_push),
        .in_ready(fifo_in_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(img_ready || !img_valid)
    );

    // registered fifo output stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            img_valid <= 1'b0;
            img_data <= '0;
        end else if (img_ready || !img_valid) begin
            img_valid <= fifo_valid;
            img_data <= fifo_data;
        end
    end

    // sequence: a download seen in idle starts with a header, otherwise all data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seq_q <= DFC_S_WAIT;
            idx_q <= '0;
            left_q <= '0;
        end else if (dn_start) begin
            idx_q <= '0;
            left_q <= dn_length;
            if (dn_length == 16'h0000) begin
                seq_q <= DFC_S_WAIT; // empty request ends download
            end else if (dfu_state == DFC_IDLE) begin
                seq_q <= DFC_S_HDR; // command header expected
            end else begin
                seq_q <= DFC_S_DATA; // pure image data
            end
        end else if (take) begin
            left_q <= left_q - 16'h0001;
            case (seq_q)
                DFC_S_HDR: begin
                    idx_q <= idx_q + 3'h1;
                    if (hdr_done) begin
                        // only a program header lets trailing bytes through
                        if (left_q == 16'h0001) begin
                            seq_q <= DFC_S_WAIT;
                        end else if (op == `DFC_OP_PROG) begin
                            seq_q <= DFC_S_DATA;
                        end else begin
                            seq_q <= DFC_S_SKIP;
                        end
                    end
                end
                default: begin
                    if (left_q == 16'h0001) begin
                        seq_q <= DFC_S_WAIT;
                    end
                end
            endcase
        end
    end

    // header byte capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                command_header_bytes[i] <= 8'h00;
            end
        end else if ((seq_q == DFC_S_HDR) && take) begin
            command_header_bytes[idx_q] <= dn_data[7:0];
        end
    end

    // end-of-download pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dn_end <= 1'b0;
        end else begin
            dn_end <= dn_start && (dn_length == 16'h0000);
        end
    end

    // command strobes and parameters, one pulse per decoded header except binary flag 0x06, which pulses nothing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prog_cmd <= 1'b0;
            read_cmd <= 1'b0;
            check_cmd <= 1'b0;
            erase_cmd <= 1'b0;
            info_cmd <= 1'b0;
            reset_cmd <= 1'b0;
            cmd_error <= 1'b0;
            cmd_start_block <= '0;
            cmd_length <= '0;
            cmd_byte_addr <= '0;
        end else begin
            prog_cmd <= hdr_done && (op == `DFC_OP_PROG);
            read_cmd <= hdr_done && (op == `DFC_OP_READ);
            check_cmd <= hdr_done && (op == `DFC_OP_CHECK);
            erase_cmd <= hdr_done && (op == `DFC_OP_ERASE);
            info_cmd <= hdr_done && (op == `DFC_OP_INFO);
            reset_cmd <= hdr_done && (op == `DFC_OP_RESET);
            // unknown opcodes go to the error path
            cmd_error <= hdr_done && ((op == 8'h00) || (op > `DFC_OP_RESET));
            if (hdr_done) begin
                cmd_start_block <= f_block;
                // block number times 1024 gives the byte address
                cmd_byte_addr <= {16'h0000, f_block} << `DFC_BLOCK_SHIFT;
                if (op == `DFC_OP_ERASE) begin
                    // erase size is whole blocks, bytes 6..7 ignored
                    cmd_length <= {16'h0000, command_header_bytes[`DFC_B_LEN1],
                        command_header_bytes[`DFC_B_LEN0]};
                end else begin
                    cmd_length <= f_len;
                end
            end
        end
    end

    // binary flag: prefix on after reset, off when flag byte is 1
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prefix_disable_flag <= 1'b0;
        end else if (hdr_done && (op == `DFC_OP_BIN)) begin
            prefix_disable_flag <= (command_header_bytes[`DFC_B_ARG] == `DFC_BIN_OFF);
        end
    end

    // total upload size including prefix when enabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            upload_total <= '0;
        end else if (hdr_done && (op == `DFC_OP_READ)) begin
            upload_total <= prefix_disable_flag ? f_len :
                f_len + {28'h0000000, `DFC_HDR_LEN};
        end
    end

    // status code; a finished blank check sets it, losing only to a bad opcode header
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_code <= `DFC_ST_OK;
        end else if (hdr_done && ((op == 8'h00) || (op > `DFC_OP_RESET))) begin
            status_code <= `DFC_ST_BAD_CMD;
        end else if (check_done) begin
            // blank region ok, otherwise erase-check failure
            status_code <= check_blank ? `DFC_ST_OK : `DFC_ST_CHECK_ERASED;
        end else if (hdr_done) begin
            status_code <= `DFC_ST_OK;
        end
    end

    // support query answer; other class requests are not ours
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            query_ack <= 1'b0;
            query_stall <= 1'b0;
            query_data <= '0;
        end else begin
            query_ack <= 1'b0;
            query_stall <= 1'b0;
            if (setup_valid && (setup_type == `DFC_RQ_TYPE) &&
                (setup_code == `DFC_RQ_CODE)) begin
                if ((setup_value == `DFC_RQ_VALUE) && (setup_length == `DFC_RQ_LEN)) begin
                    query_ack <= 1'b1;
                    // byte0..3: signature lo, hi, version 0x01, 0x00
                    query_data <= {`DFC_VER_HI, `DFC_VER_LO, SIGNATURE};
                end else begin
                    query_stall <= 1'b1; // malformed query refused
                end
            end
        end
    end
endmodule : dfc_decoder

// ### rtl/dfc_defines.svh
// constants for the download command decoder: opcodes, header layout, request codes
// assumes the includer is a design file of the decoder; definitions only
// Overview of operation
// - support query: class IN, code 0x42, value 0x23
// - answer signature bytes then version 0x01 0x00
// - headers decoded only when download starts idle
// - each command is exactly eight bytes
// - multi-byte parameters are little-endian
// - program 0x01: start block, 32-bit length
// - start is 1024-byte block number
// - up to 1016 image bytes follow header; the decoder passes on every byte after the header with no limit check
// - read 0x02 sets upload flash range
// - upload prefix on until binary flag set
// - blank check 0x03: start, length multiple four
// - blank result status 0x00 or 0x05
// - erase 0x04: start block, block count
// - erase counts whole blocks from start
// - zero-length download ends the data
`ifndef DFC_DEFINES_SVH
`define DFC_DEFINES_SVH
`define DFC_OP_PROG 8'h01
`define DFC_OP_READ 8'h02
`define DFC_OP_CHECK 8'h03
`define DFC_OP_ERASE 8'h04
`define DFC_OP_INFO 8'h05
`define DFC_OP_BIN 8'h06
`define DFC_OP_RESET 8'h07
`define DFC_HDR_LEN 4'h8
`define DFC_HDR_LAST 3'h7
`define DFC_B_OP 3'h0
`define DFC_B_ARG 3'h1
`define DFC_B_BLK_LO 3'h2
`define DFC_B_BLK_HI 3'h3
`define DFC_B_LEN0 3'h4
`define DFC_B_LEN1 3'h5
`define DFC_B_LEN2 3'h6
`define DFC_BIN_OFF 8'h01
`define DFC_BLOCK_SHIFT 5'h0a
`define DFC_MAX_DATA 11'h3f8
`define DFC_RQ_TYPE 8'ha1
`define DFC_RQ_CODE 8'h42
`define DFC_RQ_VALUE 16'h0023
`define DFC_RQ_LEN 16'h0004
`define DFC_VER_LO 8'h01
`define DFC_VER_HI 8'h00
`define DFC_ST_OK 8'h00
`define DFC_ST_CHECK_ERASED 8'h05
`define DFC_ST_BAD_CMD 8'h01
`endif

// ### rtl/dfc_fifo.sv
// parameterised valid/ready fifo for image bytes
// assumes a single clock and asynchronous active-high reset
`timescale 1ns/1ns
module dfc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH]; // storage array
    logic [AW-1:0] wr_q; // write pointer
    logic [AW-1:0] rd_q; // read pointer
    logic [AW:0] cnt_q; // fill level
    logic push;
    logic pop;
    // full exactly when the level reaches the depth
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // storage write, no reset needed for data
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
    // pointers and level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : dfc_fifo

// ### rtl/dfc_pkg.sv
// types shared by the download command decoder
// assumes the dfu state numbers below match the external dfu state machine
package dfc_pkg;
    // dfu states as reported by the external state machine
    typedef enum logic [3:0] {
        DFC_APP_IDLE, DFC_APP_DETACH, DFC_IDLE, DFC_DN_SYNC, DFC_DN_BUSY,
        DFC_DN_IDLE, DFC_MF_SYNC, DFC_MF, DFC_MF_WAIT, DFC_UP_IDLE, DFC_ERR
    } dfc_dfu_state_e;
    // decoder sequencing
    typedef enum logic [2:0] {
        DFC_S_WAIT, DFC_S_HDR, DFC_S_DATA, DFC_S_SKIP, DFC_S_QUERY
    } dfc_seq_e;
endpackage : dfc_pkg
